// File: hdl/lde_pkg.sv
// constants for the lane decode error status block
package lde_pkg;
   localparam int          NUM_LANES          = 8;
   localparam int          NUM_LINKS          = 2;
   localparam int          NUM_CNT            = NUM_LANES * NUM_LINKS;
   localparam logic [11:0] ADDR_LINK_PAGE     = 12'h300;
   localparam logic [11:0] ADDR_THRESHOLD     = 12'h301;
   localparam logic [11:0] ADDR_CNT_CLEAR     = 12'h302;
   localparam logic [11:0] ADDR_IRQ_STATUS    = 12'h303;
   localparam logic [11:0] ADDR_IRQ_CLEAR     = 12'h304;
   localparam logic [11:0] ADDR_IRQ_ENABLE    = 12'h305;
   localparam logic [11:0] ADDR_DISP_FLAGS    = 12'h46d;
   localparam logic [11:0] ADDR_INVALID_FLAGS = 12'h46e;
   localparam logic [7:0]  THRESHOLD_RST      = 8'hff;
   localparam logic        LINK_PAGE_RST      = 1'h0;
   localparam logic [7:0]  FLAGS_RST          = 8'h00;
   localparam logic [7:0]  CNT_MAX            = 8'hff;
   localparam int          LINK_PAGE_BIT      = 0;
   localparam int          EVT_DISP_BIT       = 0;
   localparam int          EVT_INVALID_BIT    = 1;
   localparam int          NUM_IRQ            = 2;
endpackage : lde_pkg

// File: hdl/lde_cnt_if.sv
// bundle between the register block and one counter bank
`timescale 1ns/1ns
interface lde_cnt_if;
   import lde_pkg::*;
   logic [NUM_CNT-1:0] evt;
   logic [7:0]         threshold;
   logic               clear;
   logic [NUM_CNT-1:0] flags;
   modport counter (input evt, input threshold, input clear, output flags);
   modport owner   (output evt, output threshold, output clear, input flags);
endinterface : lde_cnt_if

// File: hdl/lde_err_counters.sv
// per-lane, per-link error counters with threshold flags
`timescale 1ns/1ns
module lde_err_counters
   import lde_pkg::*;
(
   input wire logic   clk,   // system clock
   input wire logic   rst,   // async reset, active high
   lde_cnt_if.counter cif    // events in, flags out
);
   logic [7:0] cnt [NUM_CNT];

   // saturate so a long burst never wraps back below threshold
   function automatic logic [7:0] lde_sat_inc(input logic [7:0] v);
      return (v == CNT_MAX) ? v : v + 8'h01;
   endfunction : lde_sat_inc

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            cnt[i] <= 8'h00;
         end
         cif.flags <= '0; // [RULE4]
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            if (cif.clear) begin
               cnt[i] <= 8'h00;
            end else if (cif.evt[i]) begin
               cnt[i] <= lde_sat_inc(cnt[i]); // [RULE5]
            end
            cif.flags[i] <= (cnt[i] >= cif.threshold); // [RULE1] [RULE2]
         end
      end
   end

   for (genvar g = 0; g < NUM_CNT; g++) begin : gChk
      countStep_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
         cif.evt[g] && !cif.clear && cnt[g] != CNT_MAX |=> cnt[g] == $past(cnt[g]) + 8'h01)
         else $error("error counter did not advance on event");
      flagSet_a: assert property (@(posedge clk) disable iff (rst) // [RULE1]
         (cnt[g] >= cif.threshold) [*2] |-> cif.flags[g])
         else $error("flag low while count at or above threshold");
      flagClr_a: assert property (@(posedge clk) disable iff (rst) // [RULE2]
         (cnt[g] < cif.threshold) [*2] |-> !cif.flags[g])
         else $error("flag high while count below threshold");
      cntClear_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
         cif.clear |=> cnt[g] == 8'h00)
         else $error("error counter not cleared");
   end

   satCover_c: cover property (@(posedge clk) disable iff (rst) cnt[0] == CNT_MAX);
endmodule : lde_err_counters

// File: hdl/lde_status_top.sv
// lane decode error status registers: counters, paged flags, interrupt
//
// Contract
// (RULE1) per-lane disparity flag is 1 when its count reaches threshold, else 0
// (RULE2) 8-bit invalid-group flag register, lane n at bit n, count >= threshold
// (RULE3) flag reads return the link chosen by the page selector at 0x300
// (RULE4) all flag bits are read-only and zero after reset
// (RULE5) one counter per lane and error type, compared with the shared threshold
`timescale 1ns/1ns
module lde_status_top
   import lde_pkg::*;
(
   input  wire logic               clk,           // 125 MHz clock
   input  wire logic               rst,           // async reset, active high
   input  wire logic [11:0]        addr,          // register address
   input  wire logic [7:0]         wrData,        // write data
   input  wire logic               wrStrobe,      // one-cycle write
   input  wire logic               rdStrobe,      // one-cycle read
   output logic      [7:0]         rdData,        // read data, cycle after strobe
   input  wire logic [NUM_CNT-1:0] dispErrEvt,    // disparity error pulses, link*8+lane
   input  wire logic [NUM_CNT-1:0] invalidErrEvt, // invalid code group pulses
   output logic                    irq            // level interrupt
);
   logic               linkPage;
   logic [7:0]         errorCountThreshold;
   logic [NUM_IRQ-1:0] irqStatus;
   logic [NUM_IRQ-1:0] irqEnable;
   logic [NUM_CNT-1:0] dispPrev;
   logic [NUM_CNT-1:0] invalidPrev;

   lde_cnt_if dispIf ();
   lde_cnt_if invIf ();

   wire wrPage   = wrStrobe && (addr == ADDR_LINK_PAGE);
   wire wrThr    = wrStrobe && (addr == ADDR_THRESHOLD);
   wire wrCntClr = wrStrobe && (addr == ADDR_CNT_CLEAR);
   wire wrIrqClr = wrStrobe && (addr == ADDR_IRQ_CLEAR);
   wire wrIrqEn  = wrStrobe && (addr == ADDR_IRQ_ENABLE);

   assign dispIf.evt       = dispErrEvt;
   assign dispIf.threshold = errorCountThreshold;
   assign dispIf.clear     = wrCntClr && wrData[EVT_DISP_BIT];
   assign invIf.evt        = invalidErrEvt;
   assign invIf.threshold  = errorCountThreshold;
   assign invIf.clear      = wrCntClr && wrData[EVT_INVALID_BIT];

   lde_err_counters uDisp (
      .clk (clk),
      .rst (rst),
      .cif (dispIf)
   );

   lde_err_counters uInvalid (
      .clk (clk),
      .rst (rst),
      .cif (invIf)
   );

   // flags are paged: one link visible at a time
   wire [3:0] pageBase   = {linkPage, 3'h0};
   wire [7:0] dispSel    = dispIf.flags[pageBase +: NUM_LANES];   // [RULE3]
   wire [7:0] invalidSel = invIf.flags[pageBase +: NUM_LANES];    // [RULE3]

   // a rising flag on any link is an interrupt event, paging does not hide it
   wire dispRise    = |(dispIf.flags & ~dispPrev);
   wire invalidRise = |(invIf.flags & ~invalidPrev);
   wire [NUM_IRQ-1:0] irqEvt = {invalidRise, dispRise};
   wire [NUM_IRQ-1:0] irqClr = wrIrqClr ? wrData[NUM_IRQ-1:0] : '0;
   // set beats clear in the same cycle
   wire [NUM_IRQ-1:0] next_irqStatus = (irqStatus & ~irqClr) | irqEvt;
   // enable seen by irq in the same cycle that it is written
   wire [NUM_IRQ-1:0] next_irqEnable = wrIrqEn ? wrData[NUM_IRQ-1:0] : irqEnable;

   logic [7:0] rdValue;
   always_comb begin
      case (addr)
         ADDR_LINK_PAGE:     rdValue = {7'h00, linkPage};
         ADDR_THRESHOLD:     rdValue = errorCountThreshold;
         ADDR_IRQ_STATUS:    rdValue = {6'h00, irqStatus};
         ADDR_IRQ_ENABLE:    rdValue = {6'h00, irqEnable};
         ADDR_DISP_FLAGS:    rdValue = dispSel;    // [RULE1]
         ADDR_INVALID_FLAGS: rdValue = invalidSel; // [RULE2]
         default:            rdValue = 8'h00;
      endcase
   end

   // writes to flag addresses fall through: the flags are read-only [RULE4]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         linkPage <= LINK_PAGE_RST;
      end else if (wrPage) begin
         linkPage <= wrData[LINK_PAGE_BIT]; // [RULE3]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         errorCountThreshold <= THRESHOLD_RST;
      end else if (wrThr) begin
         errorCountThreshold <= wrData;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqEnable <= '0;
      end else begin
         irqEnable <= next_irqEnable;
      end
   end

   // edge memory of every flag on every link
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dispPrev    <= '0;
         invalidPrev <= '0;
      end else begin
         dispPrev    <= dispIf.flags;
         invalidPrev <= invIf.flags;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqStatus <= '0;
      end else begin
         irqStatus <= next_irqStatus;
      end
   end

   // built from next values so irq never lags status or enable by a cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_irqStatus & next_irqEnable);
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData <= FLAGS_RST;
      end else begin
         rdData <= rdStrobe ? rdValue : 8'h00;
      end
   end

   dispRead_a: assert property (@(posedge clk) disable iff (rst) // [RULE1]
      rdStrobe && addr == ADDR_DISP_FLAGS |=> rdData == $past(dispSel))
      else $error("disparity flag read mismatch");
   invalidRead_a: assert property (@(posedge clk) disable iff (rst) // [RULE2]
      rdStrobe && addr == ADDR_INVALID_FLAGS |=> rdData == $past(invalidSel))
      else $error("invalid group flag read mismatch");
   pageSelect_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      rdStrobe && addr == ADDR_INVALID_FLAGS && linkPage
      |=> rdData == $past(invIf.flags[15:8]))
      else $error("page 1 read did not return link 1 flags");
   flagsReadOnly_a: assert property (@(posedge clk) disable iff (rst) // [RULE4]
      wrStrobe && (addr == ADDR_DISP_FLAGS || addr == ADDR_INVALID_FLAGS)
      |=> $stable(linkPage) && $stable(errorCountThreshold) && $stable(irqEnable))
      else $error("write to read-only flag register changed state");
   stickySet_a: assert property (@(posedge clk) disable iff (rst)
      dispRise |=> irqStatus[EVT_DISP_BIT])
      else $error("disparity event lost from status");
   irqLevel_a: assert property (@(posedge clk) disable iff (rst)
      (irqStatus & irqEnable) != '0 |-> irq)
      else $error("interrupt low with enabled status set");
   rdQuiet_a: assert property (@(posedge clk) disable iff (rst)
      !rdStrobe |=> rdData == 8'h00)
      else $error("read data outside the answer cycle");
   counterFeed_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
      dispErrEvt[0] && !dispIf.clear && errorCountThreshold == 8'h01 ##1 !dispIf.clear
      |=> dispIf.flags[0])
      else $error("one error did not reach threshold of one");

   // sticky status: set wins, cleared only by writing a one
   invalidSticky_a: assert property (@(posedge clk) disable iff (rst)
      invalidRise |=> irqStatus[EVT_INVALID_BIT])
      else $error("invalid group event lost from status");
   stickyHold_a: assert property (@(posedge clk) disable iff (rst)
      irqStatus[EVT_DISP_BIT] && !irqClr[EVT_DISP_BIT] |=> irqStatus[EVT_DISP_BIT])
      else $error("status bit dropped without a clear");
   stickyClear_a: assert property (@(posedge clk) disable iff (rst)
      irqClr[EVT_DISP_BIT] && !irqEvt[EVT_DISP_BIT] |=> !irqStatus[EVT_DISP_BIT])
      else $error("status bit survived its clear");
   irqQuiet_a: assert property (@(posedge clk) disable iff (rst)
      (irqStatus & irqEnable) == '0 |-> !irq)
      else $error("interrupt high with no enabled status");

   // register writes and paged reads
   thrWrite_a: assert property (@(posedge clk) disable iff (rst)
      wrThr |=> errorCountThreshold == $past(wrData))
      else $error("threshold write did not land");
   pageWrite_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      wrPage |=> linkPage == $past(wrData[LINK_PAGE_BIT]))
      else $error("link page write did not land");
   dispPage0_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      rdStrobe && addr == ADDR_DISP_FLAGS && !linkPage
      |=> rdData == $past(dispIf.flags[7:0]))
      else $error("page 0 read did not return link 0 disparity flags");
   dispPage1_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      rdStrobe && addr == ADDR_DISP_FLAGS && linkPage
      |=> rdData == $past(dispIf.flags[15:8]))
      else $error("page 1 read did not return link 1 disparity flags");
   invalidPage0_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      rdStrobe && addr == ADDR_INVALID_FLAGS && !linkPage
      |=> rdData == $past(invIf.flags[7:0]))
      else $error("page 0 read did not return link 0 invalid flags");

   // checked at the second reset edge, once the async clear has settled
   resetClear_a: assert property (@(posedge clk) // [RULE4]
      rst [*2] |-> rdData == FLAGS_RST && !irq && dispIf.flags == '0 && invIf.flags == '0)
      else $error("flags or read data not cleared by reset");

   irqCover_c: cover property (@(posedge clk) disable iff (rst) $rose(irq));
   page1Cover_c: cover property (@(posedge clk) disable iff (rst)
      rdStrobe && linkPage && addr == ADDR_DISP_FLAGS && dispSel != 8'h00);
   invCover_c: cover property (@(posedge clk) disable iff (rst)
      rdStrobe && addr == ADDR_INVALID_FLAGS && invalidSel != 8'h00);
   clrSetCover_c: cover property (@(posedge clk) disable iff (rst) (irqClr & irqEvt) != '0);
endmodule : lde_status_top

// File: testbench/lde_tx_model.sv
// partner model: lane transmitter raising decode error pulses
`timescale 1ns/1ns
module lde_tx_model
   import lde_pkg::*;
(
   input  wire logic               clk,        // system clock
   output logic      [NUM_CNT-1:0] dispEvt,    // disparity error pulses
   output logic      [NUM_CNT-1:0] invalidEvt  // invalid code group pulses
);
   initial begin
      dispEvt    = '0;
      invalidEvt = '0;
   end
   // back-to-back errors, one a cycle, as a noisy lane gives them
   task automatic send(input logic kind, input int idx, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         if (kind) invalidEvt <= NUM_CNT'(1) << idx;
         else dispEvt <= NUM_CNT'(1) << idx;
      end
      @(posedge clk);
      dispEvt    <= '0;
      invalidEvt <= '0;
   endtask : send
endmodule : lde_tx_model

// File: testbench/tb_top.sv
// self-checking bench for the lane decode error status block
`timescale 1ns/1ns
module tb_top;
   import lde_pkg::*;
   typedef struct {logic [7:0] thr; int link; int lane; int n; logic kind; logic [7:0] flags;} lde_row_t;
   logic               clk, rst, wrStrobe, rdStrobe, irq;
   logic [11:0]        addr;
   logic [7:0]         wrData, rdData;
   logic [NUM_CNT-1:0] dispErrEvt, invalidErrEvt;
   int                 n_fail = 0, total_checks = 0, cycles = 0;
   // threshold, link, lane, errors sent, kind (1 invalid), flags expected
   lde_row_t rows[6] = '{'{8'h01, 0, 0, 1, 1'h0, 8'h01}, '{8'h03, 1, 7, 2, 1'h1, 8'h00},
      '{8'h03, 1, 7, 3, 1'h1, 8'h80}, '{8'h02, 0, 4, 5, 1'h0, 8'h10},
      '{8'h05, 1, 3, 5, 1'h0, 8'h08}, '{8'h04, 0, 2, 3, 1'h1, 8'h00}};
   lde_status_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .dispErrEvt(dispErrEvt),
      .invalidErrEvt(invalidErrEvt), .irq(irq));
   lde_tx_model u_tx (.clk(clk), .dispEvt(dispErrEvt), .invalidEvt(invalidErrEvt));
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr     <= a;
      wrData   <= d;
      wrStrobe <= 1'h1;
      @(posedge clk);
      wrStrobe <= 1'h0;
   endtask : wr
   // data stand only in the cycle after the strobe, so look just past that edge
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr     <= a;
      rdStrobe <= 1'h1;
      @(posedge clk);
      rdStrobe <= 1'h0;
      #1 check(rdData, exp);
   endtask : rd
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      rst      = 1'h1;
      addr     = 12'h000;
      wrData   = 8'h00;
      wrStrobe = 1'h0;
      rdStrobe = 1'h0;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rd(ADDR_DISP_FLAGS, FLAGS_RST);
      rd(ADDR_INVALID_FLAGS, FLAGS_RST);
      foreach (rows[i]) begin
         wr(ADDR_CNT_CLEAR, 8'h03);
         wr(ADDR_THRESHOLD, rows[i].thr);
         u_tx.send(rows[i].kind, rows[i].link * NUM_LANES + rows[i].lane, rows[i].n);
         repeat (3) @(posedge clk);
         wr(ADDR_LINK_PAGE, 8'(rows[i].link));
         rd(rows[i].kind ? ADDR_INVALID_FLAGS : ADDR_DISP_FLAGS, rows[i].flags);
         wr(ADDR_LINK_PAGE, 8'(1 - rows[i].link));
         rd(rows[i].kind ? ADDR_INVALID_FLAGS : ADDR_DISP_FLAGS, 8'h00);
      end
      wr(ADDR_INVALID_FLAGS, 8'hff);
      rd(ADDR_INVALID_FLAGS, 8'h00);
      rd(12'h7ff, 8'h00);
      wr(ADDR_CNT_CLEAR, 8'h03);
      wr(ADDR_IRQ_CLEAR, 8'h03);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      wr(ADDR_THRESHOLD, 8'h01);
      u_tx.send(1'h1, 9, 1);
      repeat (4) @(posedge clk);
      #1 check({7'h00, irq}, 8'h00);
      rd(ADDR_IRQ_STATUS, 8'h02);
      u_tx.send(1'h0, 2, 1);
      repeat (4) @(posedge clk);
      #1 check({7'h00, irq}, 8'h01);
      wr(ADDR_IRQ_CLEAR, 8'h03);
      repeat (2) @(posedge clk);
      #1 check({7'h00, irq}, 8'h00);
      wr(ADDR_LINK_PAGE, 8'h00);
      rd(ADDR_DISP_FLAGS, 8'h04);
      rd(ADDR_THRESHOLD, 8'h01);
      rd(ADDR_IRQ_ENABLE, 8'h01);
      rd(ADDR_LINK_PAGE, 8'h00);
      wr(ADDR_CNT_CLEAR, 8'h01);
      rd(ADDR_DISP_FLAGS, 8'h00);
      wr(ADDR_LINK_PAGE, 8'h01);
      wr(ADDR_INVALID_FLAGS, 8'h00);
      rd(ADDR_INVALID_FLAGS, 8'h02);
      @(posedge clk);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rd(ADDR_DISP_FLAGS, FLAGS_RST);
      rd(ADDR_THRESHOLD, THRESHOLD_RST);
      wr(ADDR_LINK_PAGE, 8'h01);
      rd(ADDR_INVALID_FLAGS, FLAGS_RST);
      stop_test();
   end
endmodule : tb_top
